/* shared/serial_shifter_pkg.sv */
/*
 * Constants for the event driven serial shifter: register offsets, mode
 * codes, field positions, reset values and timing figures.
 * Assumes a single 200 MHz clock and a plain strobe register port.
 */
package serial_shifter_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int CLK_PERIOD_NS = 5;

    // Register offsets.
    localparam logic [3:0] OFS_MODE = 4'h0;
    localparam logic [3:0] OFS_OPTION = 4'h1;
    localparam logic [3:0] OFS_COUNT = 4'h2;
    localparam logic [3:0] OFS_MASK = 4'h3;
    localparam logic [3:0] OFS_PERIOD = 4'h4;
    localparam logic [3:0] OFS_DATA = 4'h5;
    localparam logic [3:0] OFS_CHAN_CTRL = 4'h6;
    localparam logic [3:0] OFS_EVENT_TIME = 4'h7;
    localparam logic [3:0] OFS_TIMER_CTRL = 4'h8;
    localparam logic [3:0] OFS_TIMER = 4'h9;
    localparam logic [3:0] OFS_SERVICE = 4'ha;
    localparam logic [3:0] OFS_PORT = 4'hb;
    localparam logic [3:0] OFS_STATUS = 4'hc;

    // Transfer mode control codes.
    localparam logic [7:0] MODE_SYNC_RX = 8'h32;
    localparam logic [7:0] MODE_ASYNC_TX = 8'h60;

    // Serial option control fields.
    localparam int OPT_ODD_CYCLE_BIT = 1;
    localparam int OPT_PARITY_EN_BIT = 0;
    localparam int OPT_PARITY_ODD_BIT = 5;
    localparam logic [7:0] OPT_SYNC_EVEN = 8'h00;
    localparam logic [7:0] OPT_ASYNC_ODD_PARITY = 8'h21;

    // Channel control fields.
    localparam int CH_CAP_RISE_BIT = 4;
    localparam int CH_CAP_FALL_BIT = 5;
    localparam int CH_COMPARE_BIT = 6;
    localparam int CH_TOGGLE_BIT = 7;

    // Timer control fields.
    localparam int TMR_UP_BIT = 6;
    localparam int TMR_EN_BIT = 7;

    // Documented example values.
    localparam logic [7:0] MASK_BIT3 = 8'h08;
    localparam logic [7:0] COUNT_SYNC_8BIT = 8'h10;
    localparam logic [7:0] COUNT_ASYNC_8N_P_S = 8'h0a;
    localparam logic [15:0] PERIOD_9600 = 16'h01a0;
    localparam int ASYNC_MAX_BITS = 16;
    localparam int ASYNC_MAX_DATA_PARITY = 14;
    localparam int ASYNC_MAX_DATA_PLAIN = 15;

    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [15:0] RESET_WORD = 16'h0000;
    localparam logic [7:0] PORT_RESET = 8'hff;
endpackage

/* design/serial_shifter.sv */
/*
 * Event driven serial shifter: a transfer engine that moves data bits
 * through one pin of an 8 bit port, paced by a capture/compare channel
 * against a free running timer.
 * Assumes synchronous inputs, one 200 MHz clock, synchronous reset.
 */
// Overview of operation
// - Compare mode with toggle flips clock pin.
// - Capture both edges interrupts every clock toggle.
// - Sync receive samples every second channel event.
// - Sync receive count is twice the bit count.
// - Sync receive carries no parity or stop.
// - New bit enters MSB, older shift right.
// - Count decrements; zero stops service, ends transfer.
// - Mode 32H sync receive; option 00H even.
// - One-hot mask picks the data pin.
// - External clock ignores timer and period.
// - Channel control bits 4,5 capture both edges.
// - Async transmit drives one bit per compare.
// - Async frame at most sixteen bits.
// - Mode 60H async transmit; 21H odd parity.
// - Period counted in timer ticks.
// - Transmit shifts least significant bit first.
`timescale 1ns/1ps
`default_nettype none
module serial_shifter
    import serial_shifter_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [serial_shifter_pkg::ADDR_W-1:0] addr,
    input wire logic [serial_shifter_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [serial_shifter_pkg::DATA_W-1:0] rdata,
    input wire logic [7:0] port_in,
    output logic [7:0] port_out,
    output logic [7:0] port_oe,
    input wire logic shift_clk_in,
    output logic shift_clk_out,
    output logic shift_clk_oe,
    output logic end_of_transfer
);
    import serial_shifter_pkg::*;

    typedef enum logic [1:0] {IDLE, SYNC_RX, ASYNC_TX} eng_state_t;

    logic [7:0] mode_q, option_q, count_q, mask_q, chan_q, tctl_q;
    logic [7:0] port_q, dir_q;
    logic [15:0] period_q, data_q, evt_q, timer_q;
    logic service_q, parity_q, phase_q, sclk_q, sclk_in_q, done_q;
    logic [DATA_W-1:0] rdata_q;
    eng_state_t state_q;

    wire sel_mode = wr && addr == OFS_MODE;
    wire sel_event = wr && addr == OFS_EVENT_TIME;
    wire timer_run = tctl_q[TMR_EN_BIT] && tctl_q[TMR_UP_BIT];
    wire compare_mode = chan_q[CH_COMPARE_BIT];
    // Both edge capture on the external clock pin.
    // edge select bits
    wire cap_both = chan_q[CH_CAP_RISE_BIT] && chan_q[CH_CAP_FALL_BIT];
    wire cap_event = !compare_mode && cap_both && sclk_in_q != shift_clk_in;
    wire cmp_event = compare_mode && timer_run && evt_q == timer_q;
    wire chan_event = cap_event || cmp_event;
    wire active = service_q && count_q != RESET_BYTE;
    wire take = chan_event && active;
    wire is_sync = mode_q == MODE_SYNC_RX;
    wire is_async = mode_q == MODE_ASYNC_TX;
    wire odd_sel = option_q[OPT_ODD_CYCLE_BIT];
    wire rx_slot = phase_q == odd_sel;
    wire rx_bit = |(port_in & mask_q);
    wire par_en = option_q[OPT_PARITY_EN_BIT];
    wire par_odd = option_q[OPT_PARITY_ODD_BIT];
    wire last = count_q == 8'h01;
    wire par_slot = par_en && count_q == 8'h02;
    wire tx_bit = last ? 1'b1 : par_slot ? (parity_q ^ par_odd) : data_q[0];

    // Register read path, answered one cycle after the strobe.
    always_comb begin
        case (addr)
            OFS_MODE: rdata_q = {8'h00, mode_q};
            OFS_OPTION: rdata_q = {8'h00, option_q};
            OFS_COUNT: rdata_q = {8'h00, count_q};
            OFS_MASK: rdata_q = {8'h00, mask_q};
            OFS_PERIOD: rdata_q = period_q;
            OFS_DATA: rdata_q = data_q;
            OFS_CHAN_CTRL: rdata_q = {8'h00, chan_q};
            OFS_EVENT_TIME: rdata_q = evt_q;
            OFS_TIMER_CTRL: rdata_q = {8'h00, tctl_q};
            OFS_TIMER: rdata_q = timer_q;
            OFS_SERVICE: rdata_q = {15'h0000, service_q};
            OFS_PORT: rdata_q = {dir_q, port_q};
            OFS_STATUS: rdata_q = {14'h0000, done_q, sclk_q};
            default: rdata_q = RESET_WORD;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata <= RESET_WORD;
        end else begin
            rdata <= rd ? rdata_q : RESET_WORD;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            timer_q <= RESET_WORD;
            // Tracks the pin through reset so no false edge follows release.
            sclk_in_q <= shift_clk_in;
        end else begin
            if (wr && addr == OFS_TIMER) begin
                timer_q <= wdata;
            end else if (timer_run) begin
                timer_q <= timer_q + 16'h0001;
            end
            sclk_in_q <= shift_clk_in;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= IDLE;
        end else if (!active) begin
            state_q <= IDLE;
        end else if (is_sync) begin
            state_q <= SYNC_RX;
        end else if (is_async) begin
            state_q <= ASYNC_TX;
        end else begin
            state_q <= IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mode_q <= RESET_BYTE;
            option_q <= RESET_BYTE;
            count_q <= RESET_BYTE;
            mask_q <= RESET_BYTE;
            chan_q <= RESET_BYTE;
            tctl_q <= RESET_BYTE;
            period_q <= RESET_WORD;
            data_q <= RESET_WORD;
            evt_q <= RESET_WORD;
            service_q <= 1'b0;
            parity_q <= 1'b0;
            phase_q <= 1'b0;
            sclk_q <= 1'b0;
            done_q <= 1'b0;
            end_of_transfer <= 1'b0;
            port_q <= PORT_RESET;
            dir_q <= RESET_BYTE;
        end else begin
            end_of_transfer <= 1'b0;
            if (wr) begin
                case (addr)
                    OFS_MODE: mode_q <= wdata[7:0];
                    OFS_OPTION: option_q <= wdata[7:0];
                    OFS_COUNT: count_q <= wdata[7:0];
                    OFS_MASK: mask_q <= wdata[7:0];
                    OFS_PERIOD: period_q <= wdata;
                    OFS_DATA: data_q <= wdata;
                    OFS_CHAN_CTRL: chan_q <= wdata[7:0];
                    OFS_EVENT_TIME: evt_q <= wdata;
                    OFS_TIMER_CTRL: tctl_q <= wdata[7:0];
                    OFS_SERVICE: service_q <= wdata[0];
                    OFS_PORT: begin
                        port_q <= wdata[7:0];
                        dir_q <= wdata[15:8];
                    end
                    OFS_STATUS: sclk_q <= wdata[0];
                    default: begin
                    end
                endcase
                if (sel_mode) begin
                    phase_q <= 1'b0;
                    parity_q <= 1'b0;
                end
            end
            // A new event time written by firmware starts a fresh chain.
            if (cmp_event && !sel_event) begin
                evt_q <= evt_q + period_q;
                if (chan_q[CH_TOGGLE_BIT]) begin
                    sclk_q <= !sclk_q;
                end
            end
            // The clear comes first so that a set in the same cycle wins.
            if (wr && addr == OFS_STATUS && wdata[1]) begin
                done_q <= 1'b0;
            end
            if (take) begin
                count_q <= count_q - 8'h01;
                phase_q <= !phase_q;
                if (last) begin
                    service_q <= 1'b0;
                    done_q <= 1'b1;
                    end_of_transfer <= 1'b1;
                end
                if (is_sync && rx_slot) begin
                    data_q <= {rx_bit, data_q[15:1]};
                end
                if (is_async && cmp_event) begin
                    port_q <= (port_q & ~mask_q) | (tx_bit ? mask_q : 8'h00);
                    data_q <= {1'b0, data_q[15:1]};
                    parity_q <= parity_q ^ data_q[0];
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            port_out <= PORT_RESET;
            port_oe <= RESET_BYTE;
            shift_clk_out <= 1'b0;
            shift_clk_oe <= 1'b0;
        end else begin
            port_out <= port_q;
            port_oe <= dir_q;
            shift_clk_out <= sclk_q;
            shift_clk_oe <= compare_mode && chan_q[CH_TOGGLE_BIT];
        end
    end

    property p_count_dec;
        @(posedge clk) disable iff (rst)
        take && !(wr && addr == OFS_COUNT)
            |=> count_q == $past(count_q) - 8'h01;
    endproperty
    a_count_dec: assert property (p_count_dec) else $error("count slip");

    property p_eot;
        @(posedge clk) disable iff (rst)
        take && last |=> end_of_transfer && !service_q;
    endproperty
    a_eot: assert property (p_eot) else $error("no end of transfer");

    property p_msb_in;
        @(posedge clk) disable iff (rst)
        take && is_sync && rx_slot && !wr |=> data_q[15] == $past(rx_bit);
    endproperty
    a_msb_in: assert property (p_msb_in) else $error("bad msb");

    property p_skip;
        @(posedge clk) disable iff (rst)
        take && is_sync && !rx_slot && !wr |=> $stable(data_q);
    endproperty
    a_skip: assert property (p_skip) else $error("sampled off slot");

    property p_evt_step;
        @(posedge clk) disable iff (rst)
        cmp_event && !wr |=> evt_q == $past(evt_q) + $past(period_q);
    endproperty
    a_evt_step: assert property (p_evt_step) else $error("event step");

    property p_toggle;
        @(posedge clk) disable iff (rst)
        cmp_event && chan_q[CH_TOGGLE_BIT] && !wr
            |=> ##1 shift_clk_out != $past(shift_clk_out);
    endproperty
    a_toggle: assert property (p_toggle) else $error("no toggle");

    property p_tx_bit;
        @(posedge clk) disable iff (rst)
        take && is_async && cmp_event && !wr && last
            |=> ##1 (port_out & mask_q) == mask_q;
    endproperty
    a_tx_bit: assert property (p_tx_bit) else $error("stop bit low");

    property p_idle;
        @(posedge clk) disable iff (rst)
        !active |=> state_q == IDLE;
    endproperty
    a_idle: assert property (p_idle) else $error("engine not idle");

    property p_cap;
        @(posedge clk) disable iff (rst)
        !compare_mode && cap_both && active && !(wr && addr == OFS_COUNT)
            && shift_clk_in != $past(shift_clk_in)
            |=> count_q == $past(count_q) - 8'h01;
    endproperty
    a_cap: assert property (p_cap) else $error("bad capture");

    c_sync: cover property (@(posedge clk) take && is_sync && last);
    c_async: cover property (@(posedge clk) take && is_async && last);
    c_par: cover property (@(posedge clk) take && par_slot);
endmodule
`default_nettype wire

/* dv/serial_peer.sv */
/*
 * Serial peer model: makes an external shift clock with receive data,
 * and samples an asynchronous transmit line.
 * Assumes the bench clock and a pulled-up transmit line.
 */
`timescale 1ns/1ps
`default_nettype none
module serial_peer (
    input wire logic clk,
    input wire logic tx_line,
    output logic sclk,
    output logic rxd
);
    initial begin
        sclk = 1'b1;
        rxd = 1'b1;
    end

    // Each bit is shown for the first toggle, inverted for the second.
    task automatic send_sync(input logic [7:0] b, input int gap);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            rxd <= b[i];
            repeat (gap) @(posedge clk);
            sclk <= ~sclk;
            repeat (gap) @(posedge clk);
            rxd <= ~b[i];
            repeat (gap) @(posedge clk);
            sclk <= ~sclk;
            repeat (gap) @(posedge clk);
        end
    endtask

    // Waits for the start bit, then samples each bit at its middle.
    task automatic recv_async(input int p, input int n,
                              output logic [15:0] f);
        int w;
        f = 16'h0000;
        w = 0;
        while (tx_line !== 1'b0 && w < 4 * p) begin
            @(posedge clk);
            w++;
        end
        repeat (p + p / 2) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            f[i] = tx_line;
            if (i < n - 1) repeat (p) @(posedge clk);
        end
    endtask
endmodule
`default_nettype wire

/* dv/serial_shifter_tb.sv */
/*
 * Self-checking bench for the serial shifter, one task per scenario.
 * Assumes the shared package and the serial peer model.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin \
    bad_count++; $display("Error %0t got %h exp %h", $time, got, exp); end end
module serial_shifter_tb;
    import serial_shifter_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic [15:0] rdata;
    logic [7:0] port_out, port_oe, port_in;
    logic sclk_out, sclk_oe, eot, peer_sclk, peer_rxd;
    int bad_count = 0;
    int n_compared = 0;
    int eot_n = 0;
    int cycles = 0;

    always #2.5 clk = ~clk;
    // Undriven pins are pulled up; pin 3 belongs to the peer.
    assign port_in = (port_oe & port_out) |
        (~port_oe & {4'hf, peer_rxd, 3'h7});

    serial_shifter dut_u (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .port_in(port_in),
        .port_out(port_out), .port_oe(port_oe), .shift_clk_in(peer_sclk),
        .shift_clk_out(sclk_out), .shift_clk_oe(sclk_oe),
        .end_of_transfer(eot));
    serial_peer peer_u (.clk(clk), .tx_line(port_out[0]), .sclk(peer_sclk),
        .rxd(peer_rxd));

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (eot === 1'b1) eot_n <= eot_n + 1;
        if (cycles == 30000) begin
            bad_count++;
            report_and_stop();
        end
    end

    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic test_reset();
        logic [15:0] v;
        rd_reg(OFS_MODE, v);
        `CHK(v, 16'h0000)
        rd_reg(OFS_PORT, v);
        `CHK(v, {8'h00, PORT_RESET})
        wr_reg(4'hf, 16'h1234);
        rd_reg(4'hf, v);
        `CHK(v, 16'h0000)
        `CHK(sclk_oe, 1'b0)
        $display("reset test done");
    endtask

    task automatic test_sync(input logic [7:0] opt, input logic [7:0] b,
                             input int gap);
        logic [15:0] v;
        int e0;
        wr_reg(OFS_CHAN_CTRL, 16'h0000);
        wr_reg(OFS_MODE, {8'h00, MODE_SYNC_RX});
        wr_reg(OFS_OPTION, {8'h00, opt});
        wr_reg(OFS_COUNT, {8'h00, COUNT_SYNC_8BIT});
        wr_reg(OFS_MASK, {8'h00, MASK_BIT3});
        wr_reg(OFS_DATA, 16'h0000);
        wr_reg(OFS_PORT, 16'h00ff);
        wr_reg(OFS_SERVICE, 16'h0001);
        wr_reg(OFS_CHAN_CTRL, 16'h0030);
        e0 = eot_n;
        peer_u.send_sync(b, gap);
        rd_reg(OFS_DATA, v);
        `CHK(v, {opt[1] ? ~b : b, 8'h00})
        `CHK(eot_n - e0, 1)
        rd_reg(OFS_COUNT, v);
        `CHK(v, 16'h0000)
        rd_reg(OFS_STATUS, v);
        `CHK(v, 16'h0002)
        wr_reg(OFS_STATUS, 16'h0002);
        rd_reg(OFS_STATUS, v);
        `CHK(v, 16'h0000)
        peer_u.send_sync(~b, gap);
        rd_reg(OFS_DATA, v);
        `CHK(v, {opt[1] ? ~b : b, 8'h00})
        `CHK(eot_n - e0, 1)
        $display("sync test done");
    endtask

    task automatic test_async(input logic [7:0] opt, input logic [7:0] cnt,
                              input logic [15:0] d, input int n);
        logic [15:0] v, f, x, t;
        logic par;
        int e0;
        x = 16'h0000;
        par = 1'b0;
        for (int i = 0; i < n - 1; i++) begin
            x[i] = d[i];
            if (i < n - 2) par ^= d[i];
        end
        if (opt[0]) x[n-2] = ~par;
        x[n-1] = 1'b1;
        wr_reg(OFS_CHAN_CTRL, 16'h0000);
        wr_reg(OFS_MODE, {8'h00, MODE_ASYNC_TX});
        wr_reg(OFS_OPTION, {8'h00, opt});
        wr_reg(OFS_COUNT, {8'h00, cnt});
        wr_reg(OFS_MASK, 16'h0001);
        wr_reg(OFS_DATA, d);
        wr_reg(OFS_PERIOD, PERIOD_9600);
        wr_reg(OFS_PORT, 16'h0101);
        wr_reg(OFS_TIMER_CTRL, 16'h00c0);
        wr_reg(OFS_SERVICE, 16'h0001);
        e0 = eot_n;
        fork
            peer_u.recv_async(PERIOD_9600, n, f);
            begin
                wr_reg(OFS_PORT, 16'h0100);
                rd_reg(OFS_TIMER, t);
                wr_reg(OFS_EVENT_TIME, t + PERIOD_9600);
                wr_reg(OFS_CHAN_CTRL, 16'h0040);
            end
        join
        `CHK(f, x)
        `CHK(port_oe, 8'h01)
        for (int k = 0; k < 1000 && eot_n == e0; k++) @(posedge clk);
        `CHK(eot_n - e0, 1)
        rd_reg(OFS_EVENT_TIME, v);
        `CHK(v, 16'(t + PERIOD_9600 * (n + 1)))
        $display("async test done");
    endtask

    task automatic wait_toggle(output int c);
        logic s;
        s = sclk_out;
        for (int k = 0; k < 200 && sclk_out === s; k++) @(posedge clk);
        c = cycles;
    endtask

    task automatic test_gen_clock();
        logic [15:0] t;
        int c1, c2;
        wr_reg(OFS_SERVICE, 16'h0000);
        wr_reg(OFS_PERIOD, 16'h0014);
        rd_reg(OFS_TIMER, t);
        wr_reg(OFS_EVENT_TIME, t + 16'h0010);
        wr_reg(OFS_CHAN_CTRL, 16'h00c0);
        wait_toggle(c1);
        wait_toggle(c2);
        `CHK(c2 - c1, 20)
        `CHK(sclk_oe, 1'b1)
        $display("generated clock test done");
    endtask

    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        test_reset();
        test_sync(OPT_SYNC_EVEN, 8'hb4, 3);
        test_sync(8'h02, 8'h4d, 10);
        test_async(OPT_ASYNC_ODD_PARITY, COUNT_ASYNC_8N_P_S, 16'h00c5, 10);
        test_async(8'h00, 8'h10, 16'h2b5a, 16);
        test_gen_clock();
        report_and_stop();
    end
endmodule
`default_nettype wire
